/* File: core/pmc_pkg.sv */
package pmc_pkg;

  // Global power modes, highest consumption first
  typedef enum logic [1:0] {
    PMC_MODE_ACTIVE    = 2'h0,
    PMC_MODE_ALT       = 2'h1,
    PMC_MODE_SLEEP     = 2'h2,
    PMC_MODE_HIBERNATE = 2'h3
  } pmc_mode_t;

  // Sequencer states
  typedef enum logic [2:0] {
    PMC_ST_RUN    = 3'h0,
    PMC_ST_ALT    = 3'h1,
    PMC_ST_SLEEP  = 3'h2,
    PMC_ST_HIB    = 3'h3,
    PMC_ST_RESUME = 3'h4
  } pmc_state_t;

  localparam int unsigned SUBSYS_W = 8;
  localparam int unsigned CPU_BIT  = 0;
  localparam int unsigned WAKE_W   = 8;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_ACT_TMPL  = 8'h00;
  localparam logic [7:0] OFS_ALT_TMPL  = 8'h04;
  localparam logic [7:0] OFS_MODE_REQ  = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0C;
  localparam logic [7:0] OFS_WAKE_EN   = 8'h10;
  localparam logic [7:0] OFS_REG_CTRL  = 8'h14;
  localparam logic [7:0] OFS_SUBSYS_ON = 8'h18;

  // Field positions
  localparam int unsigned REG_CTRL_CORE_DIGITAL_SUPPLY_BIT = 0;
  localparam int unsigned REG_CTRL_CORE_ANALOG_SUPPLY_BIT = 1;
  localparam int unsigned STAT_MODE_LSB     = 0;
  localparam int unsigned STAT_BUSY_BIT     = 2;

  // Reset values
  localparam logic [SUBSYS_W-1:0] ACT_TMPL_RST = 8'hFF;
  localparam logic [SUBSYS_W-1:0] ALT_TMPL_RST = 8'hFE;
  localparam logic [WAKE_W-1:0]   WAKE_EN_RST  = 8'hFF;
  localparam logic [1:0]          REG_CTRL_RST = 2'h3;

  // Wake source bit positions
  localparam int unsigned WK_PIN = 0;

  // Resume times
  localparam int unsigned CLK_MHZ         = 125;
  localparam int unsigned SLEEP_WAKE_US   = 15;
  localparam int unsigned HIB_WAKE_US     = 100;
  localparam int unsigned SLEEP_WAKE_CYC  = SLEEP_WAKE_US * CLK_MHZ - 1;
  localparam int unsigned HIB_WAKE_CYC    = HIB_WAKE_US * CLK_MHZ - 1;
  localparam int unsigned CNT_W           = 14;

endpackage

/* File: core/pmc_wb_slave.sv */
`timescale 1ns/10ps
`default_nettype none
// Classic Wishbone slave, one-cycle registered ack
module pmc_wb_slave (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [31:0] rd_data_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wr_stb_o,
  output logic [7:0]       wr_adr_o,
  output logic [7:0]       wr_dat_o
);

  logic ack_q;
  logic req;

  // Ack drops after one cycle even if strobe stays high
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;

  // Ack and read data
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= rd_data_i;
      end
    end
  end

  assign wb_ack_o = ack_q;
  // Write commits on the edge that raises ack; only lane 0 is meaningful
  assign wr_stb_o = req & wb_we_i & wb_sel_i[0];
  assign wr_adr_o = wb_adr_i;
  assign wr_dat_o = wb_dat_i[7:0];

endmodule
`default_nettype wire

/* File: core/pmc_resume_timer.sv */
`timescale 1ns/10ps
`default_nettype none
// Down counter that marks the end of a resume interval
module pmc_resume_timer (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        load_i,
  input  wire logic [13:0] value_i,
  output logic             done_o
);

  logic [13:0] cnt_q;
  logic        run_q;

  // Load, then count to zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 14'h0000;
      run_q <= 1'b0;
    end else if (load_i) begin
      cnt_q <= value_i;
      run_q <= 1'b1;
    end else if (run_q) begin
      if (cnt_q == 14'h0000) begin
        run_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 14'h0001;
      end
    end
  end

  assign done_o = run_q & (cnt_q == 14'h0000);

endmodule
`default_nettype wire

/* File: core/pmc_top.sv */
// Operation
// R1 - Four modes: active, alternate active, sleep, hibernate, by falling consumption.
// R2 - In active, each subsystem follows its bit in the active template.
// R3 - Disabled subsystem gets clocks gated and analog bias switched off.
// R4 - CPU may disable itself; next wakeup turns it back on.
// R5 - Any wakeup returns to active and enables CPU regardless of template.
// R6 - After reset the mode is active.
// R7 - Alternate active uses its own smaller subsystem template.
// R8 - Sleep forces resources off but keeps slow oscillators for timers and RTC.
// R9 - Sleep wakeup resumes active within 15 us.
// R10 - Hibernate stops all clocks, retains state, wakes only on pin interrupt; the code also wakes it on dev_reset_evt_i.
// R11 - Hibernate wakeup returns to active in under 100 us.
// R12 - In hibernate, outputs hold last levels and pin interrupt setup kept.
// R13 - In hibernate only the hibernate regulator stays on.
// R14 - Outside logic must not toggle inputs above 10 kHz in hibernate.
// R15 - Core regulators start enabled; firmware may disable them for external supply.
// R16 - Firmware-enabled interrupts or any device reset wake to active.
// R17 - Mode held in a state register; lower mode only after firmware request.
`timescale 1ns/10ps
`default_nettype none
module pmc_top (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [7:0]                  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic [31:0]                      wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic [pmc_pkg::WAKE_W-1:0]  wake_src_i,
  input  wire logic                        dev_reset_evt_i,
  input  wire logic [pmc_pkg::SUBSYS_W-1:0] gpio_out_i,
  output logic [pmc_pkg::SUBSYS_W-1:0]     subsys_clk_en_o,
  output logic [pmc_pkg::SUBSYS_W-1:0]     subsys_bias_en_o,
  output logic [pmc_pkg::SUBSYS_W-1:0]     gpio_out_o,
  output logic                             gpio_hold_o,
  output logic                             low_speed_osc_en_o,
  output logic                             watch_crystal_osc_en_o,
  output logic                             core_digital_supply_reg_en_o,
  output logic                             core_analog_supply_reg_en_o,
  output logic                             sleep_reg_en_o,
  output logic                             hib_reg_en_o,
  output logic [1:0]                       mode_o
);

  logic                         wr_stb;
  logic [7:0]                   wr_adr;
  logic [7:0]                   wr_dat;
  logic [31:0]                  rd_data;
  logic [pmc_pkg::SUBSYS_W-1:0] act_tmpl_q;
  logic [pmc_pkg::SUBSYS_W-1:0] alt_tmpl_q;
  logic [pmc_pkg::WAKE_W-1:0]   wake_en_q;
  logic [1:0]                   reg_ctrl_q;
  pmc_pkg::pmc_state_t          state_q;
  pmc_pkg::pmc_state_t          state_d;
  pmc_pkg::pmc_mode_t           mode_q;
  logic                         cpu_force_q;
  logic [pmc_pkg::SUBSYS_W-1:0] en_d;
  logic [pmc_pkg::SUBSYS_W-1:0] en_q;
  logic [pmc_pkg::SUBSYS_W-1:0] gpio_q;
  logic                         mode_req;
  logic [1:0]                   req_mode;
  logic                         wake;
  logic                         wake_hib;
  logic                         tmr_load;
  logic [13:0]                  tmr_val;
  logic                         tmr_done;

  pmc_wb_slave u_wb (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_we_i   (wb_we_i),
    .wb_adr_i  (wb_adr_i),
    .wb_sel_i  (wb_sel_i),
    .wb_dat_i  (wb_dat_i),
    .rd_data_i (rd_data),
    .wb_dat_o  (wb_dat_o),
    .wb_ack_o  (wb_ack_o),
    .wr_stb_o  (wr_stb),
    .wr_adr_o  (wr_adr),
    .wr_dat_o  (wr_dat)
  );

  pmc_resume_timer u_tmr (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .load_i    (tmr_load),
    .value_i   (tmr_val),
    .done_o    (tmr_done)
  );

  // Decoded request writes
  assign mode_req = wr_stb && (wr_adr == pmc_pkg::OFS_MODE_REQ); // see R17
  assign req_mode = wr_dat[1:0];

  // Enabled interrupt wake or device reset event
  assign wake     = (|(wake_src_i & wake_en_q)) | dev_reset_evt_i; // see R16
  // Hibernate listens only to the pin interrupt unit or device reset event
  assign wake_hib = (wake_src_i[pmc_pkg::WK_PIN] & wake_en_q[pmc_pkg::WK_PIN])
                  | dev_reset_evt_i; // see R10

  // Template and config registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_tmpl_q <= pmc_pkg::ACT_TMPL_RST;
      alt_tmpl_q <= pmc_pkg::ALT_TMPL_RST;
      wake_en_q  <= pmc_pkg::WAKE_EN_RST;
      reg_ctrl_q <= pmc_pkg::REG_CTRL_RST; // see R15
    end else if (wr_stb) begin
      unique case (wr_adr)
        pmc_pkg::OFS_ACT_TMPL: begin
          act_tmpl_q <= wr_dat; // see R2
        end
        pmc_pkg::OFS_ALT_TMPL: begin
          alt_tmpl_q <= wr_dat; // see R7
        end
        pmc_pkg::OFS_WAKE_EN: begin
          wake_en_q <= wr_dat;
        end
        pmc_pkg::OFS_REG_CTRL: begin
          reg_ctrl_q <= wr_dat[1:0]; // see R15
        end
        default: begin
        end
      endcase
    end
  end

  // Resume counts; both fit the 14-bit timer
  assign tmr_load = ((state_q == pmc_pkg::PMC_ST_SLEEP) && wake)
                  || ((state_q == pmc_pkg::PMC_ST_HIB) && wake_hib);
  assign tmr_val  = (state_q == pmc_pkg::PMC_ST_HIB) ?
                    14'(pmc_pkg::HIB_WAKE_CYC) : 14'(pmc_pkg::SLEEP_WAKE_CYC); // see R9 R11

  // Mode sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      pmc_pkg::PMC_ST_RUN, pmc_pkg::PMC_ST_ALT: begin
        if (wake) begin
          state_d = pmc_pkg::PMC_ST_RUN; // see R5
        end else if (mode_req) begin
          unique case (req_mode)
            2'h0: state_d = pmc_pkg::PMC_ST_RUN;
            2'h1: state_d = pmc_pkg::PMC_ST_ALT; // see R7
            2'h2: state_d = pmc_pkg::PMC_ST_SLEEP; // see R8
            2'h3: state_d = pmc_pkg::PMC_ST_HIB; // see R10
          endcase
        end
      end
      pmc_pkg::PMC_ST_SLEEP: begin
        if (wake) begin
          state_d = pmc_pkg::PMC_ST_RESUME; // see R9
        end
      end
      pmc_pkg::PMC_ST_HIB: begin
        if (wake_hib) begin
          state_d = pmc_pkg::PMC_ST_RESUME; // see R11
        end
      end
      pmc_pkg::PMC_ST_RESUME: begin
        if (tmr_done) begin
          state_d = pmc_pkg::PMC_ST_RUN;
        end
      end
      default: begin
        state_d = pmc_pkg::PMC_ST_RUN;
      end
    endcase
  end

  // Mode state register, active after reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= pmc_pkg::PMC_ST_RUN; // see R6
    end else begin
      state_q <= state_d; // see R17
    end
  end

  // Reported global mode; resume already reports as active, not the low mode being left
  always_comb begin
    unique case (state_q)
      pmc_pkg::PMC_ST_ALT:   mode_q = pmc_pkg::PMC_MODE_ALT;
      pmc_pkg::PMC_ST_SLEEP: mode_q = pmc_pkg::PMC_MODE_SLEEP;
      pmc_pkg::PMC_ST_HIB:   mode_q = pmc_pkg::PMC_MODE_HIBERNATE;
      default:               mode_q = pmc_pkg::PMC_MODE_ACTIVE; // see R1
    endcase
  end

  // CPU forced on in active after a wake until firmware rewrites the active template
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_force_q <= 1'b0;
    end else if (wake || (state_q == pmc_pkg::PMC_ST_RESUME)) begin
      cpu_force_q <= 1'b1; // see R4
    end else if (wr_stb && (wr_adr == pmc_pkg::OFS_ACT_TMPL)) begin
      cpu_force_q <= 1'b0;
    end
  end

  // Subsystem enable selection per mode
  always_comb begin
    en_d = '0;
    unique case (state_q)
      pmc_pkg::PMC_ST_RUN: begin
        en_d = act_tmpl_q; // see R2
        en_d[pmc_pkg::CPU_BIT] = act_tmpl_q[pmc_pkg::CPU_BIT] | cpu_force_q; // see R4 R5
      end
      pmc_pkg::PMC_ST_ALT: begin
        en_d = alt_tmpl_q; // see R7
      end
      default: begin
        en_d = '0; // see R8
      end
    endcase
  end

  // Registered enables drive gating and bias together
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_q <= pmc_pkg::ACT_TMPL_RST;
    end else begin
      en_q <= en_d; // see R3
    end
  end

  assign subsys_clk_en_o  = en_q; // see R3
  assign subsys_bias_en_o = en_q; // see R3

  // GPIO retention latch; freezes on hibernate entry
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gpio_q <= '0;
    end else if (state_q != pmc_pkg::PMC_ST_HIB) begin
      gpio_q <= gpio_out_i;
    end
  end

  assign gpio_out_o  = gpio_q; // see R12
  assign gpio_hold_o = (state_q == pmc_pkg::PMC_ST_HIB); // see R12

  // Clocks and regulators per mode
  assign low_speed_osc_en_o      = (state_q != pmc_pkg::PMC_ST_HIB); // see R8 R10
  assign watch_crystal_osc_en_o  = (state_q != pmc_pkg::PMC_ST_HIB); // see R8 R10
  assign core_digital_supply_reg_en_o = reg_ctrl_q[pmc_pkg::REG_CTRL_CORE_DIGITAL_SUPPLY_BIT]
                                      & (state_q != pmc_pkg::PMC_ST_HIB); // see R13
  assign core_analog_supply_reg_en_o  = reg_ctrl_q[pmc_pkg::REG_CTRL_CORE_ANALOG_SUPPLY_BIT]
                                      & (state_q != pmc_pkg::PMC_ST_HIB); // see R13
  assign sleep_reg_en_o = (state_q != pmc_pkg::PMC_ST_HIB); // see R13
  // Hibernate regulator is always on so retention never loses power
  assign hib_reg_en_o   = 1'b1; // see R13
  assign mode_o         = mode_q;

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      pmc_pkg::OFS_ACT_TMPL:  rd_data[7:0] = act_tmpl_q;
      pmc_pkg::OFS_ALT_TMPL:  rd_data[7:0] = alt_tmpl_q;
      pmc_pkg::OFS_MODE_REQ:  rd_data[1:0] = mode_q;
      pmc_pkg::OFS_STATUS: begin
        rd_data[1:0] = mode_q;
        rd_data[pmc_pkg::STAT_BUSY_BIT] = (state_q == pmc_pkg::PMC_ST_RESUME);
      end
      pmc_pkg::OFS_WAKE_EN:   rd_data[7:0] = wake_en_q;
      pmc_pkg::OFS_REG_CTRL:  rd_data[1:0] = reg_ctrl_q;
      pmc_pkg::OFS_SUBSYS_ON: rd_data[7:0] = en_q;
      default:                rd_data = 32'h0000_0000;
    endcase
  end

  // Resume length watch; a counter stands in for a delay range too long to unroll
  logic [13:0] resume_cnt_q;
  logic        resume_from_hib_q;

  // Cycles spent resuming; saturates so a hang cannot wrap back under the bound
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resume_cnt_q <= 14'h0000;
    end else if (state_q != pmc_pkg::PMC_ST_RESUME) begin
      resume_cnt_q <= 14'h0000;
    end else if (resume_cnt_q != 14'h3FFF) begin
      resume_cnt_q <= resume_cnt_q + 14'h0001;
    end
  end

  // Which low mode the current resume started from
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resume_from_hib_q <= 1'b0;
    end else if (state_q != pmc_pkg::PMC_ST_RESUME) begin
      resume_from_hib_q <= (state_q == pmc_pkg::PMC_ST_HIB);
    end
  end

  // Wake from sleep or hibernate, then resume
  sequence s_sleep_wake;
    (state_q == pmc_pkg::PMC_ST_SLEEP) && wake;
  endsequence

  sequence s_hib_wake;
    (state_q == pmc_pkg::PMC_ST_HIB) && wake_hib;
  endsequence

  // Mode exits and resume bounds, limits taken from the wake times
  AST_RESET_ACTIVE: assert property (@(posedge clk_sys_i) // see R6
    $rose(rst_n_i) |-> mode_q == pmc_pkg::PMC_MODE_ACTIVE)
    else $error("not active after reset");
  AST_SLEEP_EXIT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R9
    s_sleep_wake |=> state_q == pmc_pkg::PMC_ST_RESUME)
    else $error("sleep wake not taken");
  AST_SLEEP_RESUME: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R9
    (state_q == pmc_pkg::PMC_ST_RESUME) && !resume_from_hib_q
      |-> resume_cnt_q < pmc_pkg::SLEEP_WAKE_US * pmc_pkg::CLK_MHZ)
    else $error("sleep resume too slow");
  AST_HIB_RESUME: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R11
    s_hib_wake |=> state_q == pmc_pkg::PMC_ST_RESUME)
    else $error("hibernate resume not started");
  AST_HIB_BOUND: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R11
    (state_q == pmc_pkg::PMC_ST_RESUME) && resume_from_hib_q
      |-> resume_cnt_q < pmc_pkg::HIB_WAKE_US * pmc_pkg::CLK_MHZ)
    else $error("hibernate resume too slow");
  AST_HIB_PIN_ONLY: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R10
    (state_q == pmc_pkg::PMC_ST_HIB) && !wake_hib |=> state_q == pmc_pkg::PMC_ST_HIB)
    else $error("left hibernate without pin");
  AST_NO_SPONT_DOWN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R17
    (state_q == pmc_pkg::PMC_ST_RUN) && !mode_req |=> state_q == pmc_pkg::PMC_ST_RUN)
    else $error("mode dropped without request");

  // Per-mode enables, regulators and retention
  AST_SLEEP_OFF: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R8
    (state_q == pmc_pkg::PMC_ST_SLEEP) ##1 (state_q == pmc_pkg::PMC_ST_SLEEP)
      |-> en_q == '0)
    else $error("resource on in sleep");
  AST_SLEEP_OSC: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R8
    (state_q == pmc_pkg::PMC_ST_SLEEP) |-> low_speed_osc_en_o && watch_crystal_osc_en_o)
    else $error("slow oscillator off in sleep");
  AST_HIB_REGS: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R13
    (state_q == pmc_pkg::PMC_ST_HIB)
      |-> !core_digital_supply_reg_en_o && !sleep_reg_en_o && hib_reg_en_o)
    else $error("regulator on in hibernate");
  AST_GPIO_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R12
    (state_q == pmc_pkg::PMC_ST_HIB) && $past(state_q == pmc_pkg::PMC_ST_HIB)
      |-> $stable(gpio_out_o))
    else $error("gpio changed in hibernate");
  AST_CPU_ON_WAKE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R4 R5
    (state_q == pmc_pkg::PMC_ST_RESUME) && tmr_done |=> ##1 en_q[pmc_pkg::CPU_BIT])
    else $error("cpu not enabled after wake");
  AST_ACT_TMPL: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R2 R3
    (state_q == pmc_pkg::PMC_ST_RUN) && $past(state_q == pmc_pkg::PMC_ST_RUN)
      && !$past(cpu_force_q) |-> en_q == $past(act_tmpl_q))
    else $error("active template not applied");
  AST_ALT_TMPL: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R7
    $past(state_q == pmc_pkg::PMC_ST_ALT) |-> en_q == $past(alt_tmpl_q))
    else $error("alt template not applied");

endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [7:0]  wake_src_i = 8'h00;
  logic        dev_reset_evt_i = 1'b0;
  logic [7:0]  gpio_out_i = 8'h00;
  logic [7:0]  subsys_clk_en_o;
  logic [7:0]  subsys_bias_en_o;
  logic [7:0]  gpio_out_o;
  logic        gpio_hold_o;
  logic        low_speed_osc_en_o;
  logic        watch_crystal_osc_en_o;
  logic        core_digital_supply_reg_en_o;
  logic        core_analog_supply_reg_en_o;
  logic        sleep_reg_en_o;
  logic        hib_reg_en_o;
  logic [1:0]  mode_o;
  int          err_count = 0;
  int          num_checks = 0;
  int          act;
  int          alt;
  int          cpu_force;
  int          md;
  logic [31:0] rd;
  logic [7:0]  frz;
  localparam int SLP = pmc_pkg::SLEEP_WAKE_US * pmc_pkg::CLK_MHZ;
  localparam int HIB = pmc_pkg::HIB_WAKE_US * pmc_pkg::CLK_MHZ;

  // 125 MHz system clock
  always #4 clk_sys_i = ~clk_sys_i;

  pmc_top i_pmc_top (.clk_sys_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wake_src_i, .dev_reset_evt_i, .gpio_out_i,
    .subsys_clk_en_o, .subsys_bias_en_o, .gpio_out_o, .gpio_hold_o, .low_speed_osc_en_o,
    .watch_crystal_osc_en_o, .core_digital_supply_reg_en_o, .core_analog_supply_reg_en_o,
    .sleep_reg_en_o, .hib_reg_en_o, .mode_o);

  task automatic stop_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Classic single cycle; no latency assumed, bounded wait for ack
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    if (n >= 20) check("bus_ack", 32'h0, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input int d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input int exp);
    bus(1'b0, a, 32'h0, 4'hF);
    check(name, rd, exp);
  endtask

  // Let pending updates land before sampling
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // Reference model of the subsystem enables
  function automatic logic [31:0] exp_en();
    case (md)
      0: return (act | cpu_force) & 8'hFF;
      1: return alt & 8'hFF;
      default: return 32'h0;
    endcase
  endfunction

  task automatic chk_state();
    check("mode", mode_o, md);
    check("clk_en", subsys_clk_en_o, exp_en());
    check("bias_en", subsys_bias_en_o, exp_en());
  endtask

  // Raise a wake source and time the return to active
  task automatic wake(input logic [7:0] w, input logic ev, input int lim);
    int n;
    @(posedge clk_sys_i);
    wake_src_i      <= w;
    dev_reset_evt_i <= ev;
    md = 0;
    cpu_force = 1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while ((subsys_clk_en_o !== exp_en() || mode_o !== 2'h0) && n < lim + 20);
    // Source stands until the return is seen, then is always dropped
    wake_src_i      <= 8'h00;
    dev_reset_evt_i <= 1'b0;
    check("wake_cycles", n <= lim + 3, 1'b1);
    settle(1);
    chk_state();
  endtask

  // Hang guard, well beyond both resume intervals
  initial begin
    #(8 * 40000);
    err_count++;
    stop_test();
  end

  initial begin
    logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h0C, 8'h1C};
    int         rv  [6] = '{32'hFF, 32'hFE, 32'hFF, 32'h3, 32'h0, 32'h0};
    void'($urandom(6));
    act = 8'hFF;
    alt = 8'hFE;
    cpu_force = 0;
    md = 0;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    settle(1);
    chk_state();
    // Reset values, then an unmapped offset that reads zero
    foreach (ofs[i]) rdchk("reset_value", ofs[i], rv[i]);
    check("dig_reg", core_digital_supply_reg_en_o, 1'b1);
    check("ana_reg", core_analog_supply_reg_en_o, 1'b1);
    // Random active templates; a write without byte lane 0 is dropped
    repeat (4) begin
      act = $urandom & 8'hFF;
      wr(pmc_pkg::OFS_ACT_TMPL, act);
      bus(1'b1, pmc_pkg::OFS_ACT_TMPL, ~act, 4'hE);
      settle(2);
      chk_state();
      rdchk("subsys_on", pmc_pkg::OFS_SUBSYS_ON, exp_en());
    end
    // Processor switches itself off, next wake brings it back
    act = $urandom & 8'hFE;
    wr(pmc_pkg::OFS_ACT_TMPL, act);
    settle(2);
    chk_state();
    wake(8'h02, 1'b0, 0);
    // Alternate active uses its own template
    alt = $urandom & 8'hFE;
    wr(pmc_pkg::OFS_ALT_TMPL, alt);
    wr(pmc_pkg::OFS_MODE_REQ, 1);
    md = 1;
    settle(2);
    chk_state();
    rdchk("status", pmc_pkg::OFS_STATUS, 1);
    wake(8'h04, 1'b0, 0);
    // Sleep: all off, slow oscillators kept
    wr(pmc_pkg::OFS_MODE_REQ, 2);
    md = 2;
    settle(2);
    chk_state();
    check("lso_sleep", low_speed_osc_en_o, 1'b1);
    check("wco_sleep", watch_crystal_osc_en_o, 1'b1);
    wake(8'h08, 1'b0, SLP);
    // Masked sources must not wake; a device reset event does
    wr(pmc_pkg::OFS_WAKE_EN, 8'h01);
    wr(pmc_pkg::OFS_MODE_REQ, 2);
    md = 2;
    @(posedge clk_sys_i);
    wake_src_i <= 8'hFE;
    settle(30);
    chk_state();
    @(posedge clk_sys_i);
    wake_src_i <= 8'h00;
    wake(8'h00, 1'b1, SLP);
    wr(pmc_pkg::OFS_WAKE_EN, 8'hFF);
    // External supply: firmware turns core regulators off
    wr(pmc_pkg::OFS_REG_CTRL, 0);
    settle(2);
    check("dig_reg_off", core_digital_supply_reg_en_o, 1'b0);
    check("ana_reg_off", core_analog_supply_reg_en_o, 1'b0);
    wr(pmc_pkg::OFS_REG_CTRL, 3);
    // Hibernate: outputs frozen, only pin wake honoured
    @(posedge clk_sys_i);
    gpio_out_i <= $urandom & 8'hFF;
    settle(3);
    frz = gpio_out_i;
    check("gpio_follow", gpio_out_o, frz);
    wr(pmc_pkg::OFS_MODE_REQ, 3);
    md = 3;
    settle(2);
    chk_state();
    check("hold", gpio_hold_o, 1'b1);
    check("osc_off", {low_speed_osc_en_o, watch_crystal_osc_en_o}, 2'h0);
    check("regs_off", {core_digital_supply_reg_en_o, core_analog_supply_reg_en_o,
                       sleep_reg_en_o, hib_reg_en_o}, 4'h1);
    @(posedge clk_sys_i);
    gpio_out_i <= ~frz;
    wake_src_i <= 8'hFE;
    settle(30);
    check("gpio_frozen", gpio_out_o, frz);
    check("hib_stay", mode_o, 2'h3);
    wake(8'h01, 1'b0, HIB);
    check("hold_off", gpio_hold_o, 1'b0);
    // Reset in mid-run from alternate active
    wr(pmc_pkg::OFS_MODE_REQ, 1);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    settle(2);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    act = 8'hFF;
    alt = 8'hFE;
    cpu_force = 0;
    md = 0;
    settle(1);
    chk_state();
    rdchk("act_after_rst", pmc_pkg::OFS_ACT_TMPL, 8'hFF);
    stop_test();
  end
endmodule
`default_nettype wire
